// >>> timer_wave_pkg.sv
// Constants, encodings and carrier types for the timer waveform and output control block
// ****************************************************************
// ****************************************************************
package timer_wave_pkg;

  // ****************************************************************
  // Bus and register map
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;
  localparam int IRQ_W = 4;
  localparam logic [ADDR_W-1:0] OFS_CTRL_FIRST = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL_SECOND = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CMP_A = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CMP_B = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_CAPTURE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_COUNTER = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_PRESCALE = 8'h24;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int CHA_HI = 7;
  localparam int CHA_LO = 6;
  localparam int CHB_HI = 5;
  localparam int CHB_LO = 4;
  localparam int WAVE_LOW_HI = 1;
  localparam int WAVE_LOW_LO = 0;
  localparam int WAVE_HIGH_HI = 4;
  localparam int WAVE_HIGH_LO = 3;
  localparam logic [7:0] CTRL_FIRST_RESET = 8'h00;
  localparam logic [7:0] CTRL_FIRST_WMASK = 8'hf3;
  localparam logic [1:0] WAVE_HIGH_RESET = 2'h0;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
  localparam int IRQ_OVF = 0;
  localparam int IRQ_MATCH_A = 1;
  localparam int IRQ_MATCH_B = 2;
  localparam int IRQ_TOP = 3;

  // ****************************************************************
  // Counter limits
  // ****************************************************************
  localparam logic [CNT_W-1:0] TOP_MAX = 16'hffff;
  localparam logic [CNT_W-1:0] TOP_8BIT = 16'h00ff;
  localparam logic [CNT_W-1:0] TOP_9BIT = 16'h01ff;
  localparam logic [CNT_W-1:0] TOP_10BIT = 16'h03ff;
  localparam logic [CNT_W-1:0] BOTTOM = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_STEP = 16'h0001;

  // ****************************************************************
  // Encodings
  // ****************************************************************
  typedef enum logic [3:0] {
    WM_NORMAL = 4'h0, WM_PC8 = 4'h1, WM_PC9 = 4'h2, WM_PC10 = 4'h3,
    WM_CTC_CMPA = 4'h4, WM_FAST8 = 4'h5, WM_FAST9 = 4'h6, WM_FAST10 = 4'h7,
    WM_PFC_CAPTURE = 4'h8, WM_PFC_CMPA = 4'h9, WM_PC_CAPTURE = 4'ha, WM_PC_CMPA = 4'hb,
    WM_CTC_CAPTURE = 4'hc, WM_RESERVED = 4'hd, WM_FAST_CAPTURE = 4'he, WM_FAST_CMPA = 4'hf
  } waveform_mode_t;

  typedef enum logic [1:0] {
    OM_OFF = 2'h0, OM_TOGGLE = 2'h1, OM_CLEAR = 2'h2, OM_SET = 2'h3
  } output_mode_t;

  typedef enum logic [1:0] {
    WC_NON_PWM = 2'h0, WC_FAST = 2'h1, WC_DUAL = 2'h2
  } wave_class_t;

  typedef enum logic {
    DIR_UP = 1'b0, DIR_DOWN = 1'b1
  } count_dir_t;

  // Per-tick view of the counter handed to each compare channel
  typedef struct packed {
    logic tick;
    logic match;
    logic at_top;
    count_dir_t dir;
    logic cmp_top;
    logic cmp_bottom;
    logic toggle_ok;
    wave_class_t wclass;
  } chan_event_t;

endpackage

// >>> compare_pin_ctrl.sv
// One compare channel: output level and pin takeover from its output field
module compare_pin_ctrl
  import timer_wave_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire output_mode_t mode_field_i,
  input wire chan_event_t ev_i,
  output logic pin_o,
  output logic drive_o
);

  // ****************************************************************
  // Action decode
  // ****************************************************************
  logic is_toggle;
  logic is_clear;
  logic is_set;
  logic toggle_dead;
  logic next_pin;

  assign is_toggle = mode_field_i == OM_TOGGLE;
  assign is_clear = mode_field_i == OM_CLEAR;
  assign is_set = mode_field_i == OM_SET;
  // Toggle in a PWM class only where allowed, else channel is disconnected
  assign toggle_dead = is_toggle && (ev_i.wclass != WC_NON_PWM) && !ev_i.toggle_ok;

  // Level the pin takes on this tick
  always_comb begin
    next_pin = pin_o;
    if (ev_i.tick) begin
      case (ev_i.wclass)
        WC_NON_PWM: begin
          if (ev_i.match) begin
            if (is_toggle) next_pin = !pin_o;
            else if (is_clear) next_pin = 1'b0;
            else if (is_set) next_pin = 1'b1;
          end
        end
        WC_FAST: begin
          if (is_toggle && !toggle_dead && ev_i.match) next_pin = !pin_o;
          else if (ev_i.at_top && (is_clear || is_set)) next_pin = is_clear;
          else if (ev_i.match && !ev_i.cmp_top && (is_clear || is_set))
            next_pin = is_set;
        end
        WC_DUAL: begin
          if (is_toggle && !toggle_dead && ev_i.match) next_pin = !pin_o;
          else if ((is_clear || is_set) && ev_i.cmp_bottom) next_pin = is_set;
          else if ((is_clear || is_set) && ev_i.cmp_top) next_pin = is_clear;
          else if ((is_clear || is_set) && ev_i.match) begin
            next_pin = (ev_i.dir == DIR_UP) ? is_set : is_clear;
          end
        end
        default: next_pin = pin_o;
      endcase
    end
  end

  // Output flops
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_o <= 1'b0;
      drive_o <= 1'b0;
    end else begin
      pin_o <= next_pin;
      drive_o <= (mode_field_i != OM_OFF) && !toggle_dead;
    end
  end

endmodule

// >>> timer_wave_ctrl.sv
// Timer waveform generation, compare output control and its APB register file
//
// The register offsets and register access over APB were chosen for this implementation.
module timer_wave_ctrl
  import timer_wave_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [DATA_W-1:0] pwdata_i,
  output logic [DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic compare_out_chan_a_o,
  output logic compare_out_chan_a_oe_o,
  output logic compare_out_chan_b_o,
  output logic compare_out_chan_b_oe_o,
  output logic irq_o
);

  // ****************************************************************
  // Reset synchroniser
  // ****************************************************************
  logic rst_meta;
  logic rst_n;

  // Release reset through two flops, assert at once
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] timer_waveform_control_a;
  logic [1:0] waveform_mode_high;
  logic [CNT_W-1:0] compare_value_chan_a;
  logic [CNT_W-1:0] compare_value_chan_b;
  logic [CNT_W-1:0] active_cmp_a;
  logic [CNT_W-1:0] active_cmp_b;
  logic [CNT_W-1:0] capture_value;
  logic [CNT_W-1:0] counter_value;
  logic [CNT_W-1:0] prescale;
  logic [CNT_W-1:0] prescale_cnt;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_enable;
  count_dir_t dir;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  logic access;
  logic wr_en;
  logic sel_ctrl_first;
  logic sel_ctrl_second;
  logic sel_cmp_a;
  logic sel_cmp_b;
  logic sel_capture;
  logic sel_counter;
  logic sel_status;
  logic sel_clear;
  logic sel_enable;
  logic sel_prescale;
  logic addr_hit;
  logic [DATA_W-1:0] rd_mux;

  // Second access cycle completes the transfer
  assign access = psel_i && penable_i && pready_o;
  assign wr_en = access && pwrite_i;
  assign sel_ctrl_first = paddr_i == OFS_CTRL_FIRST;
  assign sel_ctrl_second = paddr_i == OFS_CTRL_SECOND;
  assign sel_cmp_a = paddr_i == OFS_CMP_A;
  assign sel_cmp_b = paddr_i == OFS_CMP_B;
  assign sel_capture = paddr_i == OFS_CAPTURE;
  assign sel_counter = paddr_i == OFS_COUNTER;
  assign sel_status = paddr_i == OFS_IRQ_STATUS;
  assign sel_clear = paddr_i == OFS_IRQ_CLEAR;
  assign sel_enable = paddr_i == OFS_IRQ_ENABLE;
  assign sel_prescale = paddr_i == OFS_PRESCALE;
  assign addr_hit = sel_ctrl_first || sel_ctrl_second || sel_cmp_a || sel_cmp_b
                    || sel_capture || sel_counter || sel_status || sel_clear
                    || sel_enable || sel_prescale;

  // Read data selection, unused upper bits read zero
  always_comb begin
    rd_mux = '0;
    if (sel_ctrl_first) rd_mux[7:0] = timer_waveform_control_a & CTRL_FIRST_WMASK;
    if (sel_ctrl_second) rd_mux[WAVE_HIGH_HI:WAVE_HIGH_LO] = waveform_mode_high;
    if (sel_cmp_a) rd_mux[CNT_W-1:0] = compare_value_chan_a;
    if (sel_cmp_b) rd_mux[CNT_W-1:0] = compare_value_chan_b;
    if (sel_capture) rd_mux[CNT_W-1:0] = capture_value;
    if (sel_counter) rd_mux[CNT_W-1:0] = counter_value;
    if (sel_status) rd_mux[IRQ_W-1:0] = irq_status;
    if (sel_enable) rd_mux[IRQ_W-1:0] = irq_enable;
    if (sel_prescale) rd_mux[CNT_W-1:0] = prescale;
  end

  // Bus answer: one wait state, error on unmapped address
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= '0;
    end else begin
      pready_o <= psel_i && penable_i && !pready_o;
      pslverr_o <= psel_i && penable_i && !pready_o && !addr_hit;
      if (psel_i && penable_i && !pready_o) prdata_o <= pwrite_i ? '0 : rd_mux;
    end
  end

  // ****************************************************************
  // Waveform mode decode
  // ****************************************************************
  waveform_mode_t wave_mode;
  wave_class_t wclass;
  output_mode_t field_a;
  output_mode_t field_b;
  logic [CNT_W-1:0] top_value;
  logic immediate_update;
  logic update_at_top;
  logic update_at_bottom;
  logic flag_at_max;
  logic flag_at_top;
  logic toggle_a_ok;

  // Four-bit mode from two registers
  assign wave_mode = waveform_mode_t'({waveform_mode_high,
                     timer_waveform_control_a[WAVE_LOW_HI:WAVE_LOW_LO]});
  assign field_a = output_mode_t'(timer_waveform_control_a[CHA_HI:CHA_LO]);
  assign field_b = output_mode_t'(timer_waveform_control_a[CHB_HI:CHB_LO]);

  // Per mode: class, TOP source, reload point and flag point
  always_comb begin
    wclass = WC_NON_PWM;
    top_value = TOP_MAX;
    immediate_update = 1'b1;
    update_at_top = 1'b0;
    update_at_bottom = 1'b0;
    flag_at_max = 1'b1;
    flag_at_top = 1'b0;
    toggle_a_ok = 1'b0;
    case (wave_mode)
      WM_NORMAL: top_value = TOP_MAX;
      WM_CTC_CMPA: top_value = active_cmp_a;
      WM_CTC_CAPTURE: top_value = capture_value;
      WM_PC8, WM_PC9, WM_PC10, WM_PC_CAPTURE, WM_PC_CMPA: begin
        wclass = WC_DUAL;
        immediate_update = 1'b0;
        update_at_top = 1'b1;
        flag_at_max = 1'b0;
        toggle_a_ok = (wave_mode == WM_PC_CAPTURE) || (wave_mode == WM_PC_CMPA);
        case (wave_mode)
          WM_PC8: top_value = TOP_8BIT;
          WM_PC9: top_value = TOP_9BIT;
          WM_PC10: top_value = TOP_10BIT;
          WM_PC_CAPTURE: top_value = capture_value;
          default: top_value = active_cmp_a;
        endcase
      end
      WM_PFC_CAPTURE, WM_PFC_CMPA: begin
        wclass = WC_DUAL;
        immediate_update = 1'b0;
        update_at_bottom = 1'b1;
        flag_at_max = 1'b0;
        toggle_a_ok = 1'b1;
        top_value = (wave_mode == WM_PFC_CAPTURE) ? capture_value : active_cmp_a;
      end
      WM_FAST8, WM_FAST9, WM_FAST10, WM_FAST_CAPTURE, WM_FAST_CMPA: begin
        wclass = WC_FAST;
        immediate_update = 1'b0;
        update_at_top = 1'b1;
        flag_at_max = 1'b0;
        flag_at_top = 1'b1;
        toggle_a_ok = (wave_mode == WM_FAST_CAPTURE) || (wave_mode == WM_FAST_CMPA);
        case (wave_mode)
          WM_FAST8: top_value = TOP_8BIT;
          WM_FAST9: top_value = TOP_9BIT;
          WM_FAST10: top_value = TOP_10BIT;
          WM_FAST_CAPTURE: top_value = capture_value;
          default: top_value = active_cmp_a;
        endcase
      end
      WM_RESERVED: top_value = TOP_MAX;
      default: top_value = TOP_MAX;
    endcase
  end

  // ****************************************************************
  // Timer clock enable
  // ****************************************************************
  logic tick;

  assign tick = prescale_cnt >= prescale;

  // Divide the system clock by prescale plus one
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) prescale_cnt <= CNT_RESET;
    else prescale_cnt <= tick ? CNT_RESET : CNT_W'(prescale_cnt + CNT_STEP);
  end

  // ****************************************************************
  // Counter core
  // ****************************************************************
  logic at_top;
  logic at_bottom;
  logic at_max;
  logic [CNT_W-1:0] next_counter;
  count_dir_t next_dir;
  logic counter_wr;

  assign at_top = counter_value >= top_value;
  assign at_bottom = counter_value == BOTTOM;
  assign at_max = counter_value == TOP_MAX;
  assign counter_wr = wr_en && sel_counter;

  // Single slope wraps at TOP, dual slope turns round at TOP and BOTTOM
  always_comb begin
    next_counter = counter_value;
    next_dir = dir;
    if (counter_wr) begin
      next_counter = pwdata_i[CNT_W-1:0];
    end else if (tick) begin
      if (wclass == WC_DUAL) begin
        if (dir == DIR_UP) begin
          if (at_top) begin
            next_dir = DIR_DOWN;
            next_counter = CNT_W'(counter_value - CNT_STEP);
          end else begin
            next_counter = CNT_W'(counter_value + CNT_STEP);
          end
        end else if (at_bottom) begin
          next_dir = DIR_UP;
          next_counter = CNT_W'(counter_value + CNT_STEP);
        end else begin
          next_counter = CNT_W'(counter_value - CNT_STEP);
        end
      end else begin
        next_dir = DIR_UP;
        next_counter = at_top ? BOTTOM : CNT_W'(counter_value + CNT_STEP);
      end
    end
  end

  // Counter and direction state
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      counter_value <= CNT_RESET;
      dir <= DIR_UP;
    end else begin
      counter_value <= next_counter;
      dir <= next_dir;
    end
  end

  // ****************************************************************
  // Compare buffers
  // ****************************************************************
  logic reload;

  // Reload point depends on mode
  assign reload = immediate_update
                  || (tick && update_at_top && at_top)
                  || (tick && update_at_bottom && at_bottom);

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      active_cmp_a <= CNT_RESET;
      active_cmp_b <= CNT_RESET;
    end else if (reload) begin
      active_cmp_a <= compare_value_chan_a;
      active_cmp_b <= compare_value_chan_b;
    end
  end

  // ****************************************************************
  // Events and compare channels
  // ****************************************************************
  logic [IRQ_W-1:0] events;
  logic overflow_flag;
  chan_event_t ev_a;
  chan_event_t ev_b;

  // Overflow at MAX, TOP or BOTTOM by mode
  assign overflow_flag = tick && (flag_at_max ? at_max :
                         flag_at_top ? at_top : at_bottom);
  assign events[IRQ_OVF] = overflow_flag;
  assign events[IRQ_MATCH_A] = tick && (counter_value == active_cmp_a);
  assign events[IRQ_MATCH_B] = tick && (counter_value == active_cmp_b);
  assign events[IRQ_TOP] = tick && at_top;

  assign ev_a = '{tick: tick, match: counter_value == active_cmp_a, at_top: at_top,
                  dir: dir, cmp_top: active_cmp_a == top_value,
                  cmp_bottom: active_cmp_a == BOTTOM, toggle_ok: toggle_a_ok,
                  wclass: wclass};
  // Channel B never toggles in PWM classes
  assign ev_b = '{tick: tick, match: counter_value == active_cmp_b, at_top: at_top,
                  dir: dir, cmp_top: active_cmp_b == top_value,
                  cmp_bottom: active_cmp_b == BOTTOM, toggle_ok: 1'b0,
                  wclass: wclass};

  compare_pin_ctrl chan_a (
    .clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .mode_field_i(field_a),
    .ev_i(ev_a),
    .pin_o(compare_out_chan_a_o),
    .drive_o(compare_out_chan_a_oe_o)
  );

  compare_pin_ctrl chan_b (
    .clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .mode_field_i(field_b),
    .ev_i(ev_b),
    .pin_o(compare_out_chan_b_o),
    .drive_o(compare_out_chan_b_oe_o)
  );

  // ****************************************************************
  // Software registers
  // ****************************************************************
  logic [IRQ_W-1:0] clear_bits;

  assign clear_bits = (wr_en && sel_clear) ? pwdata_i[IRQ_W-1:0] : IRQ_RESET;

  // Control and compare writes; reserved control bits stay zero
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      timer_waveform_control_a <= CTRL_FIRST_RESET;
      waveform_mode_high <= WAVE_HIGH_RESET;
      compare_value_chan_a <= CNT_RESET;
      compare_value_chan_b <= CNT_RESET;
      capture_value <= CNT_RESET;
      prescale <= CNT_RESET;
      irq_enable <= IRQ_RESET;
    end else begin
      if (wr_en && sel_ctrl_first)
        timer_waveform_control_a <= pwdata_i[7:0] & CTRL_FIRST_WMASK;
      if (wr_en && sel_ctrl_second)
        waveform_mode_high <= pwdata_i[WAVE_HIGH_HI:WAVE_HIGH_LO];
      if (wr_en && sel_cmp_a) compare_value_chan_a <= pwdata_i[CNT_W-1:0];
      if (wr_en && sel_cmp_b) compare_value_chan_b <= pwdata_i[CNT_W-1:0];
      if (wr_en && sel_capture) capture_value <= pwdata_i[CNT_W-1:0];
      if (wr_en && sel_prescale) prescale <= pwdata_i[CNT_W-1:0];
      if (wr_en && sel_enable) irq_enable <= pwdata_i[IRQ_W-1:0];
    end
  end

  // Sticky status, a new event wins over a clear in the same cycle
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= IRQ_RESET;
      irq_o <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~clear_bits) | events;
      irq_o <= |(irq_status & irq_enable);
    end
  end

endmodule

// >>> timer_wave_chk.sv
// Port checker for the timer waveform block, bound to its top module
module timer_wave_chk
  import timer_wave_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [DATA_W-1:0] pwdata_i,
  input wire logic [DATA_W-1:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic compare_out_chan_a_o,
  input wire logic compare_out_chan_a_oe_o,
  input wire logic compare_out_chan_b_o,
  input wire logic compare_out_chan_b_oe_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************************************
  // Bus and pin ownership checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  // Completed write to the first control register
  wire logic ctl_wr = psel_i && penable_i && pready_o && pwrite_i && paddr_i == OFS_CTRL_FIRST;
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready stood longer than one cycle");
  ready_phase_a: assert property (pready_o |-> psel_i && penable_i)
    else $error("ready outside an access phase");
  err_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  wait_state_a: assert property ($rose(penable_i) && psel_i |-> !pready_o ##1 pready_o)
    else $error("access did not take one wait state");
  own_clear_a: assert property (ctl_wr && pwdata_i[7:6] == 2'h0
    |-> ##2 !compare_out_chan_a_oe_o)
    else $error("channel a kept pin with field zero");
  own_set_a: assert property (ctl_wr && pwdata_i[7:6] == 2'h3
    |-> ##2 compare_out_chan_a_oe_o)
    else $error("channel a did not take pin");
  own_b_a: assert property (ctl_wr && pwdata_i[5:4] == 2'h2
    |-> ##2 compare_out_chan_b_oe_o)
    else $error("channel b did not take pin");
  rsvd_zero_a: assert property (pready_o && !pwrite_i && paddr_i == OFS_CTRL_FIRST
    |-> prdata_o[3:2] == 2'h0)
    else $error("reserved control bits read nonzero");
  unmap_zero_a: assert property (pslverr_o && !pwrite_i |-> prdata_o == '0)
    else $error("unmapped read returned data");
  cover property (pslverr_o);
  cover property (irq_o);
  cover property ($rose(compare_out_chan_a_o));
endmodule

bind timer_wave_ctrl timer_wave_chk chk_i (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .compare_out_chan_a_o(compare_out_chan_a_o), .compare_out_chan_a_oe_o(compare_out_chan_a_oe_o),
  .compare_out_chan_b_o(compare_out_chan_b_o), .compare_out_chan_b_oe_o(compare_out_chan_b_oe_o),
  .irq_o(irq_o));

// >>> pin_load.sv
// External load on one compare output pin
module pin_load (
  input wire logic pin_i,
  input wire logic oe_i,
  output logic level_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Pull-down holds the line low while the pin driver is off
  assign level_o = oe_i ? pin_i : 1'b0;
endmodule

// >>> tb.sv
// Self-checking bench for the timer waveform and compare output block
module tb
  import timer_wave_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] OE_A = 16'hdf11;
  localparam logic [15:0] OE_B = 16'h1011;
  logic sys_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [ADDR_W-1:0] paddr_i = '0;
  logic [DATA_W-1:0] pwdata_i = '0;
  logic [DATA_W-1:0] prdata_o, rd;
  logic pready_o, pslverr_o, pa, pa_oe, pb, pb_oe, irq_o, lvl_a, lvl_b, err;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  // ****************************************************************
  // Clock, design and loads
  // ****************************************************************
  always #12.5 sys_clk_i = ~sys_clk_i;
  timer_wave_ctrl DUT (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .compare_out_chan_a_o(pa), .compare_out_chan_a_oe_o(pa_oe),
    .compare_out_chan_b_o(pb), .compare_out_chan_b_oe_o(pb_oe), .irq_o(irq_o));
  pin_load load_a (.pin_i(pa), .oe_i(pa_oe), .level_o(lvl_a));
  pin_load load_b (.pin_i(pb), .oe_i(pb_oe), .level_o(lvl_b));
  // APB transfer: setup, access until ready, release after the sampling edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do @(posedge sys_clk_i); while (pready_o !== 1'b1 && ++n < 50);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (n >= 50) failures++;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("FAIL at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic mode(input logic [3:0] m, input logic [1:0] fa, input logic [1:0] fb);
    apb(1'b1, OFS_CTRL_SECOND, {27'h0, m[3:2], 3'h0});
    apb(1'b1, OFS_CTRL_FIRST, {24'h0, fa, fb, 2'h0, m[1:0]});
  endtask
  // High cycles of one load over eight clocks
  task automatic hcnt(input logic sel, output int k);
    k = 0;
    repeat (8) begin
      @(negedge sys_clk_i);
      k += sel ? lvl_b : lvl_a;
    end
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs;
    apb(1'b0, OFS_CTRL_FIRST, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, OFS_CTRL_FIRST, 32'hff);
    apb(1'b0, OFS_CTRL_FIRST, 32'h0);
    chk(rd, 32'hf3);
    apb(1'b0, 8'hfc, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test regs done");
  endtask
  task automatic t_modes;
    for (int m = 0; m < 16; m++) begin
      if (m != 13) begin
        mode(m[3:0], 2'h1, 2'h1);
        repeat (4) @(negedge sys_clk_i);
        chk({30'h0, pa_oe, pb_oe}, {30'h0, OE_A[m], OE_B[m]});
      end
    end
    $display("test modes done");
  endtask
  task automatic t_nonpwm;
    logic prev;
    apb(1'b1, OFS_CMP_A, 32'h3);
    apb(1'b1, OFS_CMP_B, 32'h1);
    mode(4'h4, 2'h1, 2'h3);
    repeat (8) @(negedge sys_clk_i);
    prev = lvl_a;
    repeat (4) @(negedge sys_clk_i);
    chk({31'h0, lvl_a}, {31'h0, ~prev});
    chk({31'h0, lvl_b}, 32'h1);
    apb(1'b0, OFS_COUNTER, 32'h0);
    chk({31'h0, rd > 32'h3}, 32'h0);
    mode(4'h4, 2'h2, 2'h3);
    repeat (8) @(negedge sys_clk_i);
    chk({31'h0, lvl_a}, 32'h0);
    $display("test non-pwm done");
  endtask
  task automatic t_fast;
    int ka, kb;
    apb(1'b1, OFS_CMP_A, 32'h7);
    apb(1'b1, OFS_CMP_B, 32'h3);
    mode(4'hf, 2'h2, 2'h2);
    repeat (20) @(negedge sys_clk_i);
    hcnt(1'b0, ka);
    hcnt(1'b1, kb);
    chk(ka, 8);
    chk(kb, 4);
    $display("test fast done");
  endtask
  task automatic t_dual;
    int k;
    logic [31:0] cv [4] = '{32'h0, 32'h4, 32'h2, 32'h2};
    int ex [4] = '{0, 8, 4, 4};
    apb(1'b1, OFS_CMP_A, 32'h4);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, OFS_CMP_B, cv[i]);
      mode((i == 3) ? 4'h9 : 4'hb, 2'h0, 2'h2);
      repeat (20) @(negedge sys_clk_i);
      hcnt(1'b1, k);
      chk(k, ex[i]);
    end
    $display("test dual done");
  endtask
  task automatic t_irq;
    apb(1'b1, OFS_IRQ_ENABLE, 32'h0);
    apb(1'b1, OFS_CMP_A, 32'h3);
    mode(4'h4, 2'h0, 2'h0);
    apb(1'b1, OFS_IRQ_CLEAR, 32'hf);
    repeat (4) @(negedge sys_clk_i);
    apb(1'b0, OFS_IRQ_STATUS, 32'h0);
    chk({31'h0, rd[1]}, 32'h1);
    chk({31'h0, irq_o}, 32'h0);
    apb(1'b1, OFS_IRQ_ENABLE, 32'h2);
    repeat (4) @(negedge sys_clk_i);
    chk({31'h0, irq_o}, 32'h1);
    mode(4'h0, 2'h0, 2'h0);
    apb(1'b1, OFS_COUNTER, 32'hfff0);
    apb(1'b1, OFS_IRQ_CLEAR, 32'hf);
    apb(1'b0, OFS_IRQ_STATUS, 32'h0);
    chk({31'h0, rd[0]}, 32'h0);
    repeat (16) @(negedge sys_clk_i);
    apb(1'b0, OFS_IRQ_STATUS, 32'h0);
    chk({31'h0, rd[0]}, 32'h1);
    mode(4'h1, 2'h0, 2'h0);
    apb(1'b1, OFS_COUNTER, 32'hf0);
    apb(1'b1, OFS_IRQ_CLEAR, 32'hf);
    repeat (16) @(negedge sys_clk_i);
    apb(1'b0, OFS_IRQ_STATUS, 32'h0);
    chk({31'h0, rd[0]}, 32'h0);
    $display("test irq done");
  endtask
  task automatic finish_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      finish_test;
    end
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    t_regs;
    t_modes;
    t_nonpwm;
    t_fast;
    t_dual;
    t_irq;
    finish_test;
  end
endmodule
